/* core/rnt_pkg.sv */
// package: shared constants and types for the readout node / transfer card link
package rnt_pkg;
    // packet kinds on the link (one word per packet header)
    typedef enum logic [1:0] {
        RNT_PKT_SLOW_REQ,
        RNT_PKT_READOUT_REQ,
        RNT_PKT_DATA,
        RNT_PKT_SLOW_REPLY
    } rnt_pkt_t;

    localparam int unsigned CLK_HZ            = 100_000_000;
    // micro-bunch period of the system clock
    localparam int unsigned BUNCH_PERIOD_NS   = 1695;
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned BUNCH_CYCLES      = BUNCH_PERIOD_NS / CLK_PERIOD_NS;
    // highest sample clock, used to size the timestamp counter
    localparam int unsigned SAMPLE_MAX_MHZ    = 100;
    localparam int unsigned SAMPLE_MIN_MHZ    = 50;
    localparam int unsigned TS_MAX_COUNT      = BUNCH_PERIOD_NS * SAMPLE_MAX_MHZ / 1000 + 1;
    localparam int unsigned TS_W              = $clog2(TS_MAX_COUNT + 1);
    // system clock loss: no leading edge within two bunch periods
    localparam int unsigned SYSCLK_LOSS_CYC   = 2 * BUNCH_CYCLES;
    // check signal must toggle within this window
    localparam int unsigned CHECK_MIN_CYC     = 4;
    localparam int unsigned CHECK_MAX_CYC     = 2000;
    localparam int unsigned DATA_W            = 16;
    localparam int unsigned SYS_TS_W          = 48;
    localparam int unsigned CTRL_W            = 16;
    localparam int unsigned CNT_W             = 16;
    // slow-control command codes
    localparam logic [3:0]  SC_CMD_WRITE_APP  = 4'h1;
    localparam logic [3:0]  SC_CMD_RUN        = 4'h2;
    localparam logic [3:0]  SC_CMD_READ       = 4'h3;
endpackage

/* core/rnt_link_if.sv */
// interface: optical link between transfer card and readout node, one lane each way
`timescale 1ns/1ps
interface rnt_link_if;
    import rnt_pkg::*;
    // downstream: transfer card to readout node
    logic                 dn_valid;
    rnt_pkt_t             dn_kind;
    logic [DATA_W-1:0]    dn_word;
    logic [SYS_TS_W-1:0]  dn_sys_ts;
    // upstream: readout node to transfer card
    logic                 up_valid;
    rnt_pkt_t             up_kind;
    logic [DATA_W-1:0]    up_word;
    logic [SYS_TS_W-1:0]  up_sys_ts;

    modport node (input dn_valid, dn_kind, dn_word, dn_sys_ts,
                  output up_valid, up_kind, up_word, up_sys_ts);
    modport card (output dn_valid, dn_kind, dn_word, dn_sys_ts,
                  input up_valid, up_kind, up_word, up_sys_ts);
endinterface

/* core/rnt_data_buffer.sv */
// module: node data buffer with per-word parity-style check code for upset detection
`timescale 1ns/1ps
module rnt_data_buffer
    import rnt_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 64
) (
    input  wire logic             ref_clk,     // system logic clock
    input  wire logic             rst_n,       // async reset, active low
    input  wire logic             wr_valid,    // write request
    input  wire logic [WIDTH-1:0] wr_data,     // write word
    output logic                  wr_ready,    // room for a word
    output logic                  rd_valid,    // word available
    output logic [WIDTH-1:0]      rd_data,     // read word
    input  wire logic             rd_ready,    // reader takes word
    output logic                  upset_seen   // sticky: corrupted word read
);
    localparam int unsigned AW = $clog2(DEPTH);

    // check code: two parity bits over upper and lower halves catch single flips
    function automatic logic [1:0] chk(input logic [WIDTH-1:0] d);
        chk = {^d[WIDTH-1:WIDTH/2], ^d[WIDTH/2-1:0]};
    endfunction

    logic [WIDTH+1:0] mem [DEPTH];
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic        upset;
    } rnt_buf_t;
    rnt_buf_t st, next_st;

    logic full, empty, do_wr, do_rd;
    logic [WIDTH+1:0] head;
    assign full     = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    assign empty    = st.wp == st.rp;
    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign do_wr    = wr_valid && !full;
    assign do_rd    = rd_ready && !empty;
    assign head     = mem[st.rp[AW-1:0]];
    assign rd_data  = head[WIDTH-1:0];
    assign upset_seen = st.upset;

    // pointer and flag update
    always_comb begin
        next_st = st;
        if (do_wr) next_st.wp = st.wp + 1'b1;
        if (do_rd) begin
            next_st.rp = st.rp + 1'b1;
            if (chk(head[WIDTH-1:0]) != head[WIDTH+1:WIDTH]) next_st.upset = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else st <= next_st;
    end

    // storage has no reset: contents are only read once written
    always_ff @(posedge ref_clk) begin
        if (do_wr) mem[st.wp[AW-1:0]] <= {chk(wr_data), wr_data};
    end
endmodule

/* core/rnt_node.sv */
// module: readout node end of the link (fabric packet handling, watchdog, timestamp)
//
// Contract
// - fabric handles readout requests and data itself
// - slow-control requests forwarded to microcontroller
// - watchdog restarts on clock loss or bad check
// - restart reloads known-good image from memory
// - known-good image accepts remote application writes
// - stay known-good until run command, then switch
// - receive system clock, align before use
// - sample clock multiplies system clock, 50-100 MHz
// - system clock edge zeroes sample timestamp
// - link logic runs from independent local oscillator
// - one readout request per bunch, each processed
// - apply control info and system timestamp
// - spill data zero-suppressed, packed, buffered (no packing here: samples buffered one per word)
// - buffer drained onto link all supercycle
// - buffer holds a second, upset-protected memory
// - card forwards every request to each link
// - data returns on the request link
// - card merges node links into timeslice (rnt_card serves one link only, no merge)
// - one request per system period, early
// - broadcast requests processed by every node
`timescale 1ns/1ps
module rnt_node
    import rnt_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 64,
    parameter int unsigned LOSS_CYC  = SYSCLK_LOSS_CYC
) (
    input  wire logic                ref_clk,       // local oscillator clock
    input  wire logic                rst_n,         // async reset, active low
    rnt_link_if.node                 link,          // optical link lanes
    input  wire logic                sys_clk_in,    // received system clock level
    input  wire logic                sample_tick,   // sample clock enable pulse from multiplier
    input  wire logic                check_fabric,  // fabric heartbeat level
    input  wire logic                check_mcu,     // microcontroller heartbeat level
    input  wire logic                spill,         // beam spill active
    input  wire logic                adc_valid,     // digitizer sample valid
    input  wire logic [DATA_W-1:0]   adc_data,      // digitizer sample
    input  wire logic [DATA_W-1:0]   zs_threshold,  // zero-suppression threshold
    output logic                     mcu_req_valid, // slow-control word to microcontroller
    output logic [DATA_W-1:0]        mcu_req_word,  // slow-control word
    output logic                     mcu_restart,   // pulse: watchdog restart
    output logic                     reload_golden, // pulse: load known-good image
    output logic                     golden_mode,   // level: running known-good image
    output logic                     app_wr_valid,  // pulse: application memory write
    output logic [DATA_W-1:0]        app_wr_data,   // application memory data
    output logic [CTRL_W-1:0]        bunch_ctrl,    // applied readout control
    output logic [SYS_TS_W-1:0]      bunch_sys_ts,  // applied system timestamp
    output logic [TS_W-1:0]          local_ts,      // offset within micro-bunch
    output logic                     upset_seen     // buffer detected corruption
);
    typedef enum logic [1:0] {NODE_BOOT, NODE_GOLDEN, NODE_APP} rnt_mode_t;

    typedef struct packed {
        logic [1:0]          sys_sync;    // two-flop aligner
        logic                sys_prev;
        logic [15:0]         loss_cnt;
        logic                chk_f_prev;
        logic                chk_m_prev;
        logic [11:0]         chk_f_cnt;
        logic [11:0]         chk_m_cnt;
        rnt_mode_t           mode;
        logic                restart;
        logic                mcu_v;
        logic [DATA_W-1:0]   mcu_w;
        logic                app_v;
        logic [DATA_W-1:0]   app_d;
        logic                armed;       // window checks live after first cycle
        logic [CTRL_W-1:0]   ctrl;
        logic [SYS_TS_W-1:0] sys_ts;
        logic [TS_W-1:0]     ts;
        logic                up_v;
        rnt_pkt_t            up_k;
        logic [DATA_W-1:0]   up_w;
    } rnt_node_t;
    rnt_node_t st, next_st;

    logic              buf_rd_valid, buf_rd_ready, buf_wr;
    logic [DATA_W-1:0] buf_rd_data;
    logic              sys_edge, check_bad;

    // zero suppression at the buffer input, spill only
    assign buf_wr = spill && adc_valid && (adc_data > zs_threshold);
    // link is free for draining except when a slow-control reply takes a cycle on its own
    assign buf_rd_ready = !st.mcu_v;

    // a full buffer drops samples itself, so its ready flag is left unused here
    rnt_data_buffer #(
        .WIDTH (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .wr_valid   (buf_wr),
        .wr_data    (adc_data),
        .wr_ready   (),
        .rd_valid   (buf_rd_valid),
        .rd_data    (buf_rd_data),
        .rd_ready   (buf_rd_ready),
        .upset_seen (upset_seen)
    );

    assign sys_edge  = st.sys_sync[1] && !st.sys_prev;
    // heartbeat toggled too fast or not at all; the previous levels come out of
    // reset low, so a heartbeat that is high at release would look like an early
    // toggle and restart the node for nothing: the window checks wait for the
    // first cycle after reset
    assign check_bad = st.armed
                    && ((check_fabric != st.chk_f_prev && st.chk_f_cnt < CHECK_MIN_CYC)
                     || (check_mcu != st.chk_m_prev && st.chk_m_cnt < CHECK_MIN_CYC)
                     || st.chk_f_cnt >= CHECK_MAX_CYC || st.chk_m_cnt >= CHECK_MAX_CYC);

    // command code of a slow-control word sits in its top nibble; decoded for
    // both the run and the application write command
    function automatic logic [3:0] sc_cmd(input logic [DATA_W-1:0] w);
        sc_cmd = w[DATA_W-1:DATA_W-4];
    endfunction

    // one next-state process for the whole node
    always_comb begin
        next_st          = st;
        next_st.restart  = 1'b0;
        next_st.mcu_v    = 1'b0;
        next_st.app_v    = 1'b0;
        next_st.up_v     = 1'b0;
        next_st.armed    = 1'b1;
        next_st.sys_sync = {st.sys_sync[0], sys_clk_in};
        next_st.sys_prev = st.sys_sync[1];
        next_st.chk_f_prev = check_fabric;
        next_st.chk_m_prev = check_mcu;
        next_st.chk_f_cnt = (check_fabric != st.chk_f_prev) ? '0 : st.chk_f_cnt + 1'b1;
        next_st.chk_m_cnt = (check_mcu != st.chk_m_prev) ? '0 : st.chk_m_cnt + 1'b1;
        next_st.loss_cnt  = sys_edge ? '0 : st.loss_cnt + 1'b1;
        // timestamp: cleared at bunch start, counts sample ticks, saturates
        if (sys_edge) next_st.ts = '0;
        else if (sample_tick && st.ts != '1) next_st.ts = st.ts + 1'b1;

        // watchdog: restart and reload known-good image; the heartbeat counters restart
        // too, so a toggle within the next few cycles reads as too fast and restarts again
        if (st.loss_cnt >= LOSS_CYC || check_bad) begin
            next_st.restart   = 1'b1;
            next_st.mode      = NODE_GOLDEN;
            next_st.loss_cnt  = '0;
            next_st.chk_f_cnt = '0;
            next_st.chk_m_cnt = '0;
        end else if (st.mode == NODE_BOOT) begin
            next_st.mode = NODE_GOLDEN;
        end

        // downstream packets: fabric decodes every one, broadcast included
        if (link.dn_valid) begin
            unique case (link.dn_kind)
                RNT_PKT_READOUT_REQ: begin
                    next_st.ctrl   = link.dn_word;
                    next_st.sys_ts = link.dn_sys_ts;
                end
                RNT_PKT_SLOW_REQ: begin
                    next_st.mcu_v = 1'b1;
                    next_st.mcu_w = link.dn_word;
                    if (sc_cmd(link.dn_word) == SC_CMD_RUN && st.mode == NODE_GOLDEN)
                        next_st.mode = NODE_APP;
                    if (sc_cmd(link.dn_word) == SC_CMD_WRITE_APP && st.mode == NODE_GOLDEN) begin
                        next_st.app_v = 1'b1;
                        next_st.app_d = link.dn_word;
                    end
                end
                RNT_PKT_DATA, RNT_PKT_SLOW_REPLY: ; // not expected downstream
            endcase
        end

        // upstream: slow-control echo first, else buffered data, same link
        if (st.mcu_v) begin
            next_st.up_v = 1'b1;
            next_st.up_k = RNT_PKT_SLOW_REPLY;
            next_st.up_w = st.mcu_w;
        end else if (buf_rd_valid) begin
            next_st.up_v = 1'b1;
            next_st.up_k = RNT_PKT_DATA;
            next_st.up_w = buf_rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st      <= '0;
            st.mode <= NODE_BOOT;
        end else begin
            st <= next_st;
        end
    end

    assign mcu_req_valid  = st.mcu_v;
    assign mcu_req_word   = st.mcu_w;
    assign mcu_restart    = st.restart;
    assign reload_golden  = st.restart;
    assign golden_mode    = st.mode != NODE_APP;
    assign app_wr_valid   = st.app_v;
    assign app_wr_data    = st.app_d;
    assign bunch_ctrl     = st.ctrl;
    assign bunch_sys_ts   = st.sys_ts;
    assign local_ts       = st.ts;
    assign link.up_valid  = st.up_v;
    assign link.up_kind   = st.up_k;
    assign link.up_word   = st.up_w;
    assign link.up_sys_ts = st.sys_ts;
endmodule

/* core/rnt_card.sv */
// module: transfer card end of one node link (request forwarding, data collection)
`timescale 1ns/1ps
module rnt_card
    import rnt_pkg::*;
(
    input  wire logic                ref_clk,      // card clock
    input  wire logic                rst_n,        // async reset, active low
    rnt_link_if.card                 link,         // link to one readout node
    input  wire logic                rr_valid,     // readout request from run control
    input  wire logic [CTRL_W-1:0]   rr_ctrl,      // request control info
    input  wire logic [SYS_TS_W-1:0] rr_sys_ts,    // request system timestamp
    input  wire logic                sc_valid,     // slow-control word to send
    input  wire logic [DATA_W-1:0]   sc_word,      // slow-control word
    output logic                     sc_ready,     // slow-control word taken
    output logic                     ts_valid,     // timeslice word out
    output logic [DATA_W-1:0]        ts_word,      // timeslice data
    output logic [SYS_TS_W-1:0]      ts_sys_ts,    // timestamp of that word
    output logic                     sc_reply_valid, // slow-control reply
    output logic [DATA_W-1:0]        sc_reply_word   // slow-control reply word
);
    typedef struct packed {
        logic                dv;
        rnt_pkt_t            dk;
        logic [DATA_W-1:0]   dw;
        logic [SYS_TS_W-1:0] dts;
        logic                tv;
        logic [DATA_W-1:0]   tw;
        logic [SYS_TS_W-1:0] tts;
        logic                rv;
        logic [DATA_W-1:0]   rw;
    } rnt_card_t;
    rnt_card_t st, next_st;

    // readout requests win the lane; slow control waits for as long as rr_valid is high
    assign sc_ready = !rr_valid;

    always_comb begin
        next_st    = st;
        next_st.dv = 1'b0;
        next_st.tv = 1'b0;
        next_st.rv = 1'b0;
        if (rr_valid) begin
            next_st.dv  = 1'b1;
            next_st.dk  = RNT_PKT_READOUT_REQ;
            next_st.dw  = rr_ctrl;
            next_st.dts = rr_sys_ts;
        end else if (sc_valid) begin
            next_st.dv = 1'b1;
            next_st.dk = RNT_PKT_SLOW_REQ;
            next_st.dw = sc_word;
        end
        // collect upstream data words into the timeslice stream; slow-control replies go to the reply port
        if (link.up_valid && link.up_kind == RNT_PKT_DATA) begin
            next_st.tv  = 1'b1;
            next_st.tw  = link.up_word;
            next_st.tts = link.up_sys_ts;
        end
        if (link.up_valid && link.up_kind == RNT_PKT_SLOW_REPLY) begin
            next_st.rv = 1'b1;
            next_st.rw = link.up_word;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else st <= next_st;
    end

    assign link.dn_valid  = st.dv;
    assign link.dn_kind   = st.dk;
    assign link.dn_word   = st.dw;
    assign link.dn_sys_ts = st.dts;
    assign ts_valid       = st.tv;
    assign ts_word        = st.tw;
    assign ts_sys_ts      = st.tts;
    assign sc_reply_valid = st.rv;
    assign sc_reply_word  = st.rw;
endmodule

/* dv/rnt_link_monitor.sv */
// checker: link-level relations between the node end and the card end
`timescale 1ns/1ps
module rnt_link_monitor (
    input wire logic                         ref_clk,   // link logic clock
    input wire logic                         rst_n,     // async reset, active low
    input wire logic                         dn_valid,  // card to node word valid
    input wire rnt_pkg::rnt_pkt_t            dn_kind,   // downstream packet kind
    input wire logic [rnt_pkg::DATA_W-1:0]   dn_word,   // downstream word
    input wire logic [rnt_pkg::SYS_TS_W-1:0] dn_sys_ts, // downstream timestamp
    input wire logic                         up_valid,  // node to card word valid
    input wire rnt_pkg::rnt_pkt_t            up_kind,   // upstream packet kind
    input wire logic [rnt_pkg::DATA_W-1:0]   up_word,   // upstream word
    input wire logic [rnt_pkg::SYS_TS_W-1:0] up_sys_ts  // upstream timestamp
);
    import rnt_pkg::*;

    // one clock domain, so clocking and reset are given once
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // a slow-control word comes back as a reply exactly two cycles on
    property p_slow_echo;
        dn_valid && dn_kind == RNT_PKT_SLOW_REQ |->
            ##2 up_valid && up_kind == RNT_PKT_SLOW_REPLY && up_word == $past(dn_word, 2);
    endproperty
    a_slow_echo: assert property (p_slow_echo)
        else $error("slow-control reply missing or wrong");

    // a reply never appears without its request two cycles earlier
    property p_reply_cause;
        up_valid && up_kind == RNT_PKT_SLOW_REPLY |->
            $past(dn_valid, 2) && $past(dn_kind, 2) == RNT_PKT_SLOW_REQ;
    endproperty
    a_reply_cause: assert property (p_reply_cause)
        else $error("slow-control reply without a request");

    // the node answers only with kinds that travel upstream
    property p_up_kinds;
        up_valid |-> up_kind inside {RNT_PKT_DATA, RNT_PKT_SLOW_REPLY};
    endproperty
    a_up_kinds: assert property (p_up_kinds)
        else $error("upstream word of a downstream kind");

    // the card sends only request kinds downstream
    property p_dn_kinds;
        dn_valid |-> dn_kind inside {RNT_PKT_SLOW_REQ, RNT_PKT_READOUT_REQ};
    endproperty
    a_dn_kinds: assert property (p_dn_kinds)
        else $error("downstream word of an upstream kind");

    // readout requests stay in fabric logic and draw no slow-control reply
    property p_readout_silent;
        dn_valid && dn_kind == RNT_PKT_READOUT_REQ |->
            ##2 !(up_valid && up_kind == RNT_PKT_SLOW_REPLY);
    endproperty
    a_readout_silent: assert property (p_readout_silent)
        else $error("readout request answered as slow control");

    // a readout request's system timestamp is applied by the next cycle
    property p_ts_applied;
        dn_valid && dn_kind == RNT_PKT_READOUT_REQ |=> up_sys_ts == $past(dn_sys_ts);
    endproperty
    a_ts_applied: assert property (p_ts_applied)
        else $error("readout timestamp not applied");
endmodule

/* dv/testbench.sv */
// testbench: node and card joined by the link, driven from both user sides
`timescale 1ns/1ps
module testbench;
    import rnt_pkg::*;

    logic ref_clk, rst_n, rr_valid, sc_valid, sys_clk_in, sample_tick, check_fabric, check_mcu;
    logic spill, adc_valid, mcu_req_valid, mcu_restart, reload_golden, golden_mode, upset_seen;
    logic app_wr_valid, sc_ready, ts_valid, sc_reply_valid, sys_run, hb_stop, ts_chk;
    logic got_mcu, got_app, got_reply, got_rst, got_ts;
    logic [CTRL_W-1:0]   rr_ctrl, bunch_ctrl;
    logic [SYS_TS_W-1:0] rr_sys_ts, bunch_sys_ts, ts_sys_ts, ts_stamp;
    logic [DATA_W-1:0]   sc_word, adc_data, zs_threshold, mcu_req_word, sc_reply_word, ts_word;
    logic [DATA_W-1:0]   mcu_word, reply_word, ts_data, app_wr_data, app_word;
    logic [TS_W-1:0]     local_ts, ts_prev;
    logic [7:0]          drops;
    logic [3:0]          sc_code [4] = '{SC_CMD_WRITE_APP, SC_CMD_READ, SC_CMD_RUN, SC_CMD_WRITE_APP};
    logic [DATA_W-1:0]   dat_val [3] = '{16'h0234, 16'h0100, 16'h0345};
    int                  checked, num_errors;

    rnt_link_if rnt_link_if_inst ();
    rnt_node #(.BUF_DEPTH(64), .LOSS_CYC(40)) rnt_node_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(rnt_link_if_inst.node),
        .sys_clk_in(sys_clk_in), .sample_tick(sample_tick), .check_fabric(check_fabric),
        .check_mcu(check_mcu), .spill(spill), .adc_valid(adc_valid), .adc_data(adc_data),
        .zs_threshold(zs_threshold), .mcu_req_valid(mcu_req_valid), .mcu_req_word(mcu_req_word),
        .mcu_restart(mcu_restart), .reload_golden(reload_golden), .golden_mode(golden_mode),
        .app_wr_valid(app_wr_valid), .app_wr_data(app_wr_data), .bunch_ctrl(bunch_ctrl),
        .bunch_sys_ts(bunch_sys_ts), .local_ts(local_ts), .upset_seen(upset_seen));
    rnt_card rnt_card_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(rnt_link_if_inst.card), .rr_valid(rr_valid),
        .rr_ctrl(rr_ctrl), .rr_sys_ts(rr_sys_ts), .sc_valid(sc_valid), .sc_word(sc_word),
        .sc_ready(sc_ready), .ts_valid(ts_valid), .ts_word(ts_word), .ts_sys_ts(ts_sys_ts),
        .sc_reply_valid(sc_reply_valid), .sc_reply_word(sc_reply_word));
    rnt_link_monitor rnt_link_monitor_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .dn_valid(rnt_link_if_inst.dn_valid),
        .dn_kind(rnt_link_if_inst.dn_kind), .dn_word(rnt_link_if_inst.dn_word),
        .dn_sys_ts(rnt_link_if_inst.dn_sys_ts), .up_valid(rnt_link_if_inst.up_valid),
        .up_kind(rnt_link_if_inst.up_kind), .up_word(rnt_link_if_inst.up_word),
        .up_sys_ts(rnt_link_if_inst.up_sys_ts));

    always #5 ref_clk = ~ref_clk;

    // micro-bunch clock of 30 cycles, shortened so the watchdog limit can be 40
    always begin
        repeat (15) @(posedge ref_clk);
        #1;
        if (sys_run) sys_clk_in = ~sys_clk_in;
    end

    // heartbeats toggle every 10 cycles, well inside the allowed window
    always begin
        repeat (10) @(posedge ref_clk);
        #1;
        if (!hb_stop) begin
            check_fabric = ~check_fabric;
            check_mcu = ~check_mcu;
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pulses are caught here, since they stand for one cycle only
    always @(posedge ref_clk) begin
        if (mcu_req_valid === 1'b1) begin
            got_mcu = 1'b1;
            mcu_word = mcu_req_word;
        end
        if (app_wr_valid === 1'b1) begin
            got_app = 1'b1;
            app_word = app_wr_data;
        end
        if (sc_reply_valid === 1'b1) begin
            got_reply = 1'b1;
            reply_word = sc_reply_word;
        end
        if (mcu_restart === 1'b1 && reload_golden === 1'b1) got_rst = 1'b1;
        if (ts_valid === 1'b1) begin
            got_ts = 1'b1;
            ts_data = ts_word;
            ts_stamp = ts_sys_ts;
        end
        if (ts_chk && local_ts < ts_prev) begin
            drops = drops + 8'h01;
            chk(ts_prev >= 8'h1c && ts_prev <= 8'h1e, 1'b1);
            chk(local_ts <= 8'h01, 1'b1);
        end
        ts_prev = local_ts;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic clr();
        {got_mcu, got_app, got_reply, got_rst, got_ts} = 5'h00;
        reply_word = 'x;
    endtask

    task automatic send_rr(input logic [CTRL_W-1:0] c, input logic [SYS_TS_W-1:0] t);
        rr_valid = 1'b1;
        rr_ctrl = c;
        rr_sys_ts = t;
        tick(1);
        rr_valid = 1'b0;
        tick(4);
        chk(bunch_ctrl, c);
        chk(bunch_sys_ts, t);
    endtask

    // slow-control word held until the card takes it
    task automatic send_sc(input logic [DATA_W-1:0] w);
        clr();
        sc_valid = 1'b1;
        sc_word = w;
        @(posedge ref_clk);
        while (sc_ready !== 1'b1) @(posedge ref_clk);
        #1;
        sc_valid = 1'b0;
        tick(6);
    endtask

    task automatic give_verdict();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {ref_clk, rst_n, rr_valid, sc_valid, sys_clk_in, check_fabric, check_mcu} = 7'h00;
        {spill, adc_valid, hb_stop, ts_chk, sys_run, sample_tick} = 6'h03;
        {rr_ctrl, rr_sys_ts, sc_word, adc_data, drops, checked, num_errors} = '0;
        zs_threshold = 16'h0100;
        ts_prev = '0;
        clr();
        repeat (12) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        tick(3);
        chk(golden_mode, 1'b1);
        send_rr(16'h5a01, 48'h0000_1234_5678);
        send_rr(16'ha502, 48'h0000_1234_5679);
        // write, read, run, then write again once the application runs
        for (int i = 0; i < 4; i++) begin
            send_sc({sc_code[i], 12'h3c5});
            chk(got_mcu, 1'b1);
            chk(mcu_word, {sc_code[i], 12'h3c5});
            if (i == 0) chk(app_word, {sc_code[i], 12'h3c5});
            chk(reply_word, {sc_code[i], 12'h3c5});
            chk(got_app, i == 0);
            chk(golden_mode, i < 2);
        end
        // above threshold in spill, at threshold, and outside the spill
        for (int i = 0; i < 3; i++) begin
            clr();
            spill = (i < 2);
            adc_valid = 1'b1;
            adc_data = dat_val[i];
            tick(1);
            adc_valid = 1'b0;
            tick(8);
            chk(got_ts, i == 0);
            if (i == 0) chk(ts_data, dat_val[i]);
            if (i == 0) chk(ts_stamp, 48'h0000_1234_5679);
        end
        ts_chk = 1'b1;
        tick(300);
        ts_chk = 1'b0;
        chk(drops >= 8'h08, 1'b1);
        // no sample ticks: the count is cleared at the next bunch start and then stands
        sample_tick = 1'b0;
        tick(40);
        chk(local_ts, 8'h00);
        sample_tick = 1'b1;
        clr();
        hb_stop = 1'b1;
        tick(2100);
        chk(got_rst, 1'b1);
        chk(golden_mode, 1'b1);
        hb_stop = 1'b0;
        tick(300);
        send_sc({SC_CMD_RUN, 12'h000});
        chk(golden_mode, 1'b0);
        clr();
        sys_run = 1'b0;
        tick(100);
        chk(got_rst, 1'b1);
        chk(golden_mode, 1'b1);
        sys_run = 1'b1;
        tick(100);
        chk(upset_seen, 1'b0);
        give_verdict();
    end
endmodule
